// *** bench/pic_cpu_model.sv ***
// CPU core model: runs acknowledge cycles and takes the answered level as its own.
// Assumes the controller answers within a few cycles of the request edge.
`timescale 1ns/1ps
module pic_cpu_model (
    input  wire logic       clk_sys,
    output logic [2:0]      cpu_level = 3'h0,
    output logic            iack_req = 1'b0,
    input  wire logic       iack_done,
    input  wire logic [7:0] iack_vector,
    input  wire logic       transfer_ack_n,
    input  wire logic       autovector_n,
    input  wire logic [2:0] sr_level
);
    logic [7:0] got_vec = 8'h00;
    logic       got_av  = 1'b0;
    logic [2:0] got_sr  = 3'h0;
    logic       got_ok  = 1'b0;

    task automatic rte();
        cpu_level <= 3'h0;
    endtask

    // A missing or malformed answer leaves got_ok low for the bench to report
    task automatic ack();
        got_ok = 1'b0;
        iack_req <= 1'b1;
        @(posedge clk_sys);
        iack_req <= 1'b0;
        repeat (6) begin
            @(posedge clk_sys);
            if (iack_done === 1'b1 && got_ok !== 1'b1) begin
                got_ok = (transfer_ack_n ^ autovector_n) === 1'b1;
                got_vec = iack_vector;
                got_av = ~autovector_n;
                got_sr = sr_level;
                cpu_level <= sr_level;
            end
        end
    endtask
endmodule // pic_cpu_model

// *** bench/prioritized_interrupt_controller_test.sv ***
// Self-checking bench of the interrupt controller: registers, arbitration, acknowledge, port pins.
// Assumes pic_cpu_model on the acknowledge side; peripherals and pins are driven here.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin errors++; $display("BAD %s expected %0h seen %0h", nm, ex, gt); end end
module prioritized_interrupt_controller_test;
    logic        clk_sys = 1'b0, arst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0]  ext_irq_pin_i, ext_irq_pin_o, ext_irq_pin_oe, ext_irq_pin_weak_hi, iack_vector;
    logic [7:0]  ext_drv = 8'hFF;
    logic [6:0]  per_req, per_ack, per_arm = 7'h00, per_done = 7'h00;
    logic [2:0]  cpu_level, irq_level, sr_level;
    logic        iack_req, iack_done, transfer_ack_n, autovector_n, irq_out;
    int          errors = 0, compares = 0, seed = 32'h428b;
    int          lv[15], pd[15];

    always #5 clk_sys = ~clk_sys;

    // Driven low wins over the outside driver; weak high never does
    assign ext_irq_pin_i = (ext_irq_pin_oe & ext_irq_pin_o) | (~ext_irq_pin_oe & ext_drv);

    pic_ctrl dut (.clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_irq_pin_i, .ext_irq_pin_o, .ext_irq_pin_oe, .ext_irq_pin_weak_hi,
        .per_req, .per_ack, .cpu_level, .irq_level, .iack_req, .iack_done, .iack_vector,
        .transfer_ack_n, .autovector_n, .sr_level, .irq_out);

    pic_cpu_model cpu (.clk_sys, .cpu_level, .iack_req, .iack_done, .iack_vector, .transfer_ack_n,
        .autovector_n, .sr_level);

    // Peripherals hold their request until acknowledged; disarming clears the record
    assign per_req = per_arm & ~per_done;

    always @(posedge clk_sys) begin
        per_done <= (per_arm == 7'h00) ? 7'h00 : (per_done | per_ack);
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
        // One idle edge keeps bready from being lowered and raised in one time step
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK("rdata", ex, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        @(posedge clk_sys);
    endtask

    // Index order is the tie-break order: pins 7..0, then peripheral bits 0..6
    function automatic int pick();
        int b;
        b = -1;
        for (int s = 0; s < 15; s++)
            if (pd[s] != 0 && lv[s] > 0 && (b < 0 || lv[s] > lv[b])) b = s;
        return b;
    endfunction

    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        stop_test();
    end

    initial begin
        int w, nest, av, cl;
        logic [31:0] pl;
        logic [6:0]  dprev;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rd(8'h00, 32'h00);
        rd(8'h20, 32'h0F);
        rd(pic_pkg::OFS_PORT_LAT, 32'hFF);
        rd(8'h58, 32'h00, pic_pkg::RESP_SLVERR);
        wr(8'h58, 32'hFF, pic_pkg::RESP_SLVERR);
        // Pin 2 enabled and vectored; pin 4 left disabled must ignore its edge
        wr(8'h08, 32'h65);
        wr(8'h28, 32'hA5);
        wr(8'h10, 32'h06);
        ext_drv <= 8'hEB;
        repeat (8) @(posedge clk_sys);
        `CHK("irq_level", 5, irq_level)
        rd(8'h10, 32'h06);
        cpu.ack();
        `CHK("answered", 1, cpu.got_ok)
        `CHK("vector", 8'hA5, cpu.got_vec)
        `CHK("sr_level", 7, cpu.got_sr)
        rd(8'h08, 32'h65);
        ext_drv <= 8'hFF;
        rd(pic_pkg::OFS_IRQ_STAT, 32'h03);
        `CHK("irq_out", 0, irq_out)
        wr(pic_pkg::OFS_IRQ_MASK, 32'h01);
        @(posedge clk_sys);
        `CHK("irq_out", 1, irq_out)
        wr(pic_pkg::OFS_IRQ_STAT, 32'h01);
        @(posedge clk_sys);
        `CHK("irq_out", 0, irq_out)
        rd(pic_pkg::OFS_IRQ_STAT, 32'h02);
        // Equal levels first, then random levels, nesting mode alternating
        for (int rep = 0; rep < 3; rep++) begin
            nest = rep % 2;
            av = (rep < 2);
            cl = 0;
            cpu.rte();
            wr(pic_pkg::OFS_SYS_CFG, 32'(nest));
            pl = 32'h0;
            for (int s = 0; s < 15; s++) begin
                lv[s] = (rep == 0) ? 3 : $unsigned($random(seed)) % 8;
                pd[s] = 1;
                if (s < 8) begin
                    wr(8'(4 * (7 - s)), 32'((av ? 8'h68 : 8'h48) | lv[s]));
                    wr(8'(8'h20 + 4 * (7 - s)), 32'(8'h87 - s));
                end else begin
                    pl = pl | (32'(lv[s]) << (3 * (s - 8)));
                end
            end
            wr(pic_pkg::OFS_PER_LVL, pl);
            per_arm <= 7'h7F;
            repeat (3) @(posedge clk_sys);
            w = pick();
            while (w >= 0) begin
                `CHK("irq_level", (lv[w] > cl) ? lv[w] : 0, irq_level)
                dprev = per_done;
                cpu.ack();
                cl = nest ? lv[w] : 7;
                `CHK("vector", (w < 8 && av) ? 8'h87 - w : 0, cpu.got_vec)
                `CHK("autovector", (w >= 8 || !av), cpu.got_av)
                `CHK("sr_level", cl, cpu.got_sr)
                repeat (3) @(posedge clk_sys);
                `CHK("per_ack", dprev | ((w < 8) ? 0 : 1 << (w - 8)), per_done)
                pd[w] = 0;
                w = pick();
            end
            `CHK("irq_level", 0, irq_level)
            per_arm <= 7'h00;
        end
        // Pin 5 as a port bit: latch low drives hard, latch high only weakly
        wr(8'h14, 32'h80);
        wr(pic_pkg::OFS_PORT_LAT, 32'hDF);
        repeat (6) @(posedge clk_sys);
        `CHK("oe", 8'h20, ext_irq_pin_oe)
        `CHK("weak_hi", 8'h00, ext_irq_pin_weak_hi)
        `CHK("pin_o", 8'h00, ext_irq_pin_o)
        rd(pic_pkg::OFS_PORT_LAT, 32'hDF);
        rd(pic_pkg::OFS_PORT_PIN, 32'hDF);
        wr(pic_pkg::OFS_PORT_PIN, 32'hFF);
        @(posedge clk_sys);
        `CHK("oe", 8'h00, ext_irq_pin_oe)
        `CHK("weak_hi", 8'h20, ext_irq_pin_weak_hi)
        ext_drv <= 8'hDF;
        repeat (6) @(posedge clk_sys);
        rd(pic_pkg::OFS_PORT_PIN, 32'hDF);
        rd(pic_pkg::OFS_PORT_LAT, 32'hFF);
        rd(8'h14, 32'h80);
        stop_test();
    end
endmodule // prioritized_interrupt_controller_test

// *** logic/pic_ctrl.sv ***
// Prioritised interrupt controller: 8 external falling-edge pins, 7 peripheral requests.
// Assumes an AXI4-Lite master on clk_sys and a CPU core running acknowledge cycles.
`timescale 1ns/1ps
module pic_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  ext_irq_pin_i,
    output logic [7:0]       ext_irq_pin_o,
    output logic [7:0]       ext_irq_pin_oe,
    output logic [7:0]       ext_irq_pin_weak_hi,
    input  wire logic [6:0]  per_req,
    output logic [6:0]       per_ack,
    input  wire logic [2:0]  cpu_level,
    output logic [2:0]       irq_level,
    input  wire logic        iack_req,
    output logic             iack_done,
    output logic [7:0]       iack_vector,
    output logic             transfer_ack_n,
    output logic             autovector_n,
    output logic [2:0]       sr_level,
    output logic             irq_out
);
    localparam int NS = pic_pkg::NUM_SRC;

    logic [7:0]  cfg_reg [8];
    logic [7:0]  vec_reg [8];
    logic [7:0]  lat_reg;
    logic [20:0] per_lvl_reg;
    logic        nest_reg;
    logic [2:0]  stat_reg;
    logic [2:0]  mask_reg;
    logic [7:0]  s1_reg, s2_reg, s3_reg, filt_reg;
    logic [7:0]  fall;
    logic [3:0]  win_idx;
    logic [2:0]  win_lvl;
    logic [2:0]  lvl [NS];
    logic [NS-1:0] req;

    // Write channel state
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        aw_hold_reg, w_hold_reg;
    logic        wr_go;
    logic        wr_map;
    logic [7:0]  wbyte;

    function automatic logic hit_map(input logic [7:0] a);
        hit_map = (a[1:0] == 2'h0) && (a <= pic_pkg::OFS_IRQ_MASK);
    endfunction

    // Three-stage sampling; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg   <= 8'hFF;
            s2_reg   <= 8'hFF;
            s3_reg   <= 8'hFF;
            filt_reg <= 8'hFF;
        end else begin
            s1_reg <= ext_irq_pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < 8; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    filt_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            fall[i] = filt_reg[i] && !s2_reg[i] && !s3_reg[i];
        end
    end

    // Source table: index 0 wins ties, matching the fixed order
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl[i] = cfg_reg[7 - i][2:0];
            req[i] = cfg_reg[7 - i][pic_pkg::CFG_PEND]
                     && (cfg_reg[7 - i][7:6] == pic_pkg::FUNC_IRQ);
        end
        for (int i = 0; i < 7; i++) begin
            lvl[8 + i] = per_lvl_reg[3 * i +: 3];
            req[8 + i] = per_req[i];
        end
    end

    always_comb begin
        win_idx = 4'h0;
        win_lvl = pic_pkg::LVL_OFF;
        for (int i = 0; i < NS; i++) begin
            if (req[i] && (lvl[i] > win_lvl)) begin
                win_lvl = lvl[i];
                win_idx = 4'(i);
            end
        end
    end

    // Only levels above the running level are forwarded
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_level <= 3'h0;
        end else begin
            irq_level <= (win_lvl > cpu_level) ? win_lvl : pic_pkg::LVL_OFF;
        end
    end

    // Acknowledge cycle: answer one cycle after the request
    logic       ack_ok;
    assign ack_ok = iack_req && (win_lvl != pic_pkg::LVL_OFF);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            iack_done      <= 1'b0;
            iack_vector    <= 8'h00;
            transfer_ack_n <= 1'b1;
            autovector_n   <= 1'b1;
            sr_level       <= 3'h0;
            per_ack        <= 7'h00;
        end else begin
            iack_done      <= ack_ok;
            transfer_ack_n <= 1'b1;
            autovector_n   <= 1'b1;
            per_ack        <= 7'h00;
            if (ack_ok) begin
                sr_level    <= nest_reg ? win_lvl : pic_pkg::LVL_MAX;
                if (win_idx < 4'h8 && cfg_reg[3'(7 - win_idx)][pic_pkg::CFG_AVSEL]) begin
                    iack_vector    <= vec_reg[3'(7 - win_idx)];
                    transfer_ack_n <= 1'b0;
                end else begin
                    iack_vector  <= 8'h00;
                    autovector_n <= 1'b0;
                end
                if (win_idx >= 4'h8) begin
                    per_ack[3'(win_idx - 4'h8)] <= 1'b1;
                end
            end
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    assign wr_go         = aw_hold_reg && w_hold_reg;
    assign wr_map        = hit_map(awaddr_reg);
    assign wbyte         = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pic_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = wr_go && wstrb_reg[0] && (awaddr_reg == a);
    endfunction

    // Per-pin configuration, pending flag and vector
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int n = 0; n < 8; n++) begin
                cfg_reg[n] <= pic_pkg::RST_EXT_CFG;
                vec_reg[n] <= pic_pkg::RST_EXT_VEC;
            end
        end else begin
            for (int n = 0; n < 8; n++) begin
                if (wr_at(8'(pic_pkg::OFS_EXT_CFG + 4 * n))) begin
                    cfg_reg[n] <= {wbyte[7:5], 1'b0, wbyte[3:0]};
                end else if (ack_ok && win_idx == 4'(7 - n)) begin
                    cfg_reg[n][pic_pkg::CFG_PEND] <= 1'b0;
                end
                if (fall[n] && cfg_reg[n][7:6] == pic_pkg::FUNC_IRQ) begin
                    cfg_reg[n][pic_pkg::CFG_PEND] <= 1'b1;
                end
                if (wr_at(8'(pic_pkg::OFS_EXT_VEC + 4 * n))) begin
                    vec_reg[n] <= wbyte;
                end
            end
        end
    end

    // Shared port latch, written through either port register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lat_reg <= pic_pkg::RST_PORT_LAT;
        end else if (wr_at(pic_pkg::OFS_PORT_LAT) || wr_at(pic_pkg::OFS_PORT_PIN)) begin
            lat_reg <= wbyte;
        end
    end

    // A 1 only pulls weakly high so an outside driver can win; a 0 drives hard
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            ext_irq_pin_o[n]       = 1'b0;
            ext_irq_pin_oe[n]      = (cfg_reg[n][7:6] == pic_pkg::FUNC_PORT) && !lat_reg[n];
            ext_irq_pin_weak_hi[n] = (cfg_reg[n][7:6] == pic_pkg::FUNC_PORT) && lat_reg[n];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            per_lvl_reg <= 21'h0;
            nest_reg    <= 1'b0;
            mask_reg    <= 3'h0;
        end else if (wr_go) begin
            if (awaddr_reg == pic_pkg::OFS_PER_LVL) begin
                // Only 21 bits exist, so the third byte lane is cut to five bits
                if (wstrb_reg[0]) begin
                    per_lvl_reg[7:0] <= wdata_reg[7:0];
                end
                if (wstrb_reg[1]) begin
                    per_lvl_reg[15:8] <= wdata_reg[15:8];
                end
                if (wstrb_reg[2]) begin
                    per_lvl_reg[20:16] <= wdata_reg[20:16];
                end
            end
            if (wr_at(pic_pkg::OFS_SYS_CFG)) begin
                nest_reg <= wdata_reg[pic_pkg::SYS_NEST];
            end
            if (wr_at(pic_pkg::OFS_IRQ_MASK)) begin
                mask_reg <= wdata_reg[2:0];
            end
        end
    end

    // Sticky status; a new event beats a simultaneous write-one-to-clear
    logic [2:0] ev;
    assign ev = {1'b0, |fall, iack_done};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stat_reg <= 3'h0;
        end else begin
            stat_reg <= (stat_reg & ~(wr_at(pic_pkg::OFS_IRQ_STAT) ? wdata_reg[2:0] : 3'h0)) | ev;
        end
    end

    assign irq_out = |(stat_reg & mask_reg);

    // AXI4-Lite read path, one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= pic_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= hit_map(s_axi_araddr) ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
            s_axi_rdata  <= 32'h0;
            if (!hit_map(s_axi_araddr)) begin
                s_axi_rdata <= 32'h0;
            end else if (s_axi_araddr < pic_pkg::OFS_EXT_VEC) begin
                s_axi_rdata[7:0] <= cfg_reg[s_axi_araddr[4:2]];
            end else if (s_axi_araddr < pic_pkg::OFS_PORT_LAT) begin
                s_axi_rdata[7:0] <= vec_reg[s_axi_araddr[4:2]];
            end else begin
                unique case (s_axi_araddr)
                    pic_pkg::OFS_PORT_LAT: s_axi_rdata[7:0] <= lat_reg;
                    pic_pkg::OFS_PORT_PIN: s_axi_rdata[7:0] <= filt_reg;
                    pic_pkg::OFS_PER_LVL:  s_axi_rdata[20:0] <= per_lvl_reg;
                    pic_pkg::OFS_SYS_CFG:  s_axi_rdata[0] <= nest_reg;
                    pic_pkg::OFS_IRQ_STAT: s_axi_rdata[2:0] <= stat_reg;
                    pic_pkg::OFS_IRQ_MASK: s_axi_rdata[2:0] <= mask_reg;
                    default:               s_axi_rdata <= 32'h0;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_lvl_forward;
        @(posedge clk_sys) disable iff (!arst_n)
        (win_lvl > cpu_level) |=> (irq_level == $past(win_lvl));
    endproperty
    a_lvl_forward: assert property (p_lvl_forward) else $error("winner level not forwarded");

    property p_lvl_block;
        @(posedge clk_sys) disable iff (!arst_n)
        (win_lvl <= cpu_level) |=> (irq_level == 3'h0);
    endproperty
    a_lvl_block: assert property (p_lvl_block) else $error("blocked level forwarded");

    property p_nest;
        @(posedge clk_sys) disable iff (!arst_n)
        (ack_ok && nest_reg) |=> (sr_level == $past(win_lvl));
    endproperty
    a_nest: assert property (p_nest) else $error("nested level wrong");

    property p_nonest;
        @(posedge clk_sys) disable iff (!arst_n)
        (ack_ok && !nest_reg) |=> (sr_level == 3'h7);
    endproperty
    a_nonest: assert property (p_nonest) else $error("level 7 not loaded");

    property p_one_answer;
        @(posedge clk_sys) disable iff (!arst_n)
        iack_done |-> (transfer_ack_n != autovector_n);
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("acknowledge answer not exclusive");

    property p_edge_pend;
        @(posedge clk_sys) disable iff (!arst_n)
        (fall[2] && cfg_reg[2][7:6] == pic_pkg::FUNC_IRQ) |=> cfg_reg[2][pic_pkg::CFG_PEND];
    endproperty
    a_edge_pend: assert property (p_edge_pend) else $error("edge did not set pending");

    property p_no_edge_off;
        @(posedge clk_sys) disable iff (!arst_n)
        (!cfg_reg[0][pic_pkg::CFG_PEND] && cfg_reg[0][7:6] != pic_pkg::FUNC_IRQ && !wr_go)
            |=> !cfg_reg[0][pic_pkg::CFG_PEND];
    endproperty
    a_no_edge_off: assert property (p_no_edge_off) else $error("pending set while not in irq mode");

    property p_ack_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        (ack_ok && win_idx == 4'h7 && !fall[0] && !wr_go) |=> !cfg_reg[0][pic_pkg::CFG_PEND];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("acknowledge left pending set");

    property p_pin_read;
        @(posedge clk_sys) disable iff (!arst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == pic_pkg::OFS_PORT_PIN)
            |=> (s_axi_rdata[7:0] == $past(filt_reg));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin register read wrong");

    c_vectored: cover property (@(posedge clk_sys) disable iff (!arst_n) iack_done && !transfer_ack_n);
    c_autovec:  cover property (@(posedge clk_sys) disable iff (!arst_n) iack_done && !autovector_n);
    c_per_ack:  cover property (@(posedge clk_sys) disable iff (!arst_n) |per_ack);
endmodule // pic_ctrl

// *** logic/pic_pkg.sv ***
// Package of the prioritised interrupt controller: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite bus, one aligned word per register.
package pic_pkg;
    localparam int NUM_EXT = 8;
    localparam int NUM_PER = 7;
    localparam int NUM_SRC = 15;

    localparam logic [7:0] OFS_EXT_CFG  = 8'h00;   // + 4*n, external_irq_config n
    localparam logic [7:0] OFS_EXT_VEC  = 8'h20;   // + 4*n, external_irq_vector n
    localparam logic [7:0] OFS_PORT_LAT = 8'h40;   // port_latch_upper/lower joined
    localparam logic [7:0] OFS_PORT_PIN = 8'h44;   // port_pin_read_upper/lower joined
    localparam logic [7:0] OFS_PER_LVL  = 8'h48;   // 3 bits per peripheral source
    localparam logic [7:0] OFS_SYS_CFG  = 8'h4C;   // system_config_two
    localparam logic [7:0] OFS_IRQ_STAT = 8'h50;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h54;

    localparam int CFG_FUNC_HI = 7;                // pin_function_sel_hi
    localparam int CFG_FUNC_LO = 6;                // pin_function_sel_lo
    localparam int CFG_AVSEL   = 5;                // autovector_select
    localparam int CFG_PEND    = 3;                // pending_request_flag
    localparam int SYS_NEST    = 0;

    localparam logic [1:0] FUNC_OFF  = 2'h0;
    localparam logic [1:0] FUNC_IRQ  = 2'h1;
    localparam logic [1:0] FUNC_PORT = 2'h2;

    localparam logic [7:0] RST_EXT_CFG  = 8'h00;
    localparam logic [7:0] RST_EXT_VEC  = 8'h0F;
    localparam logic [7:0] RST_PORT_LAT = 8'hFF;
    localparam logic [2:0] LVL_MAX      = 3'h7;
    localparam logic [2:0] LVL_OFF      = 3'h0;

    localparam int ST_ACK_DONE = 0;
    localparam int ST_EXT_EDGE = 1;
    localparam int ST_W        = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
